// file: hdl/itc_ctrl.sv
// Transfer interrupt flag and bus wait control, two-wire mode
//
// Notes on behaviour
// - Flag rises after 8 or 9 bits of a byte, or on bus error.
// - While flag is 1, SCL held low, except flags from an immediate bus error.
// - Reserved address in first byte sets flag at 8th bit.
// - Lost arbitration in later bytes: 8th bit if wait select 1, else 9th.
// - Lost arbitration in first byte sets flag at 9th bit.
// - No DMA, wait select 1: tx empty or slave rx no FIFO, 8th bit.
// - DMA, wait select 1, master: bus idle sets flag at 8th bit.
// - NACK sets flag at 9th bit unless a stop is requested.
// - FIFO receive with data and no reserved address: 9th bit.
// - Bus error: flag now if control 0, at 9th bit if 1.
// - No DMA: tx empty while sending, or rx without FIFO, 9th bit.
// - No DMA, wait select 0, later bytes: tx empty or slave rx, 9th.
// - FIFO full sets flag in slave receive without DMA, never in master receive.
// - DMA: slave tx empty, or master idle with select 0, 9th bit.
// - Writing 0 clears flag; also master off or restart while active.
// - Writing 1 without DMA does not set the flag; with DMA, writing 1 sets the flag.
// - DMA master idle in later bytes raises flag but no status request.
// - After disable, late reception may still set flags.
// - Mode field codes 0 to 4; others refused; reserved bits read 0.
// - Receive request on full or overrun; transmit request on empty.
// - Flag requests an interrupt only while its enable is 1.
// - Wait select 0 waits after acknowledge, 1 after data bits.
`timescale 1ns/1ps
`default_nettype none
module itc_ctrl import itc_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_n,
    // Data path status and requests
    input wire itc_env_t env,
    output itc_irq_t irq
);
    typedef struct packed {
        itc_lnk_t lnk;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic act, mrole, dir, rsa, nack, al, bus_fault_flag, beri, intf;
        logic wait_point_sel, dma, master_select, bec, allow, fe, en;
        logic [2:0] mode;
        logic rx_irq_en, tx_irq_en;
        logic pready, pslverr;
        logic [31:0] prdata;
        logic scl_o, scl_oe_n;
        itc_irq_t irq;
    } itc_st_t;

    itc_st_t q;
    itc_st_t n;
    logic [1:0] lv, rs, fl;
    logic wr, wr_ctrl, wr_mode, at8, at9, start, stop, be_imm;
    logic fbq, nxt, m, s, rx, rsa8, stopreq, set8, set9, set_sw, set_any;
    logic clr, mapped, mid;
    logic [7:0] ofs;
    logic [31:0] wd;

    itc_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({sda_i, scl_i}),
        .lvl(lv),
        .rise(rs),
        .fall(fl)
    );

    assign ofs = 8'(paddr);
    assign wd = pwdata;
    // Writes land at the access edge only
    assign wr = psel & penable & pwrite & q.pready & ~q.pslverr;
    assign wr_ctrl = wr & (ofs == ITC_CTRL_OFS);
    assign wr_mode = wr & (ofs == ITC_MODE_OFS);
    assign mapped = (ofs == ITC_CTRL_OFS) | (ofs == ITC_MODE_OFS)
        | (ofs == ITC_STAT_OFS);
    assign start = fl[1] & lv[0];
    assign stop = rs[1] & lv[0];
    assign at8 = fl[0] & (q.cnt == BIT_DATA);
    assign at9 = fl[0] & (q.cnt == BIT_ACK);
    assign fbq = q.lnk == ST_FIRST;
    assign nxt = q.lnk == ST_NEXT;
    assign m = q.mrole;
    assign s = ~q.mrole;
    assign rx = ~q.dir;
    // Start or stop inside a byte is a bus error; a legal stop or restart
    // after a later byte lands on its first clock, so bit 1 is exempt there
    assign mid = (q.lnk != ST_IDLE) & (q.cnt != CNT_RST)
        & (fbq | (q.cnt != 4'h1));
    assign be_imm = (start | stop) & ~q.bec & mid;
    assign rsa8 = fbq & ((q.sh[7:4] == RSV_LO) | (q.sh[7:4] == RSV_HI));
    assign stopreq = q.mrole & q.act & ~q.master_select;

    assign set8 = at8 & (rsa8
        | q.wait_point_sel & q.al & nxt
        | ~q.dma & q.wait_point_sel & nxt
          & (env.tx_buf_empty | s & rx & ~q.fe)
        | q.dma & q.wait_point_sel & m & nxt & env.tx_bus_idle);

    assign set9 = at9 & (q.al & fbq
        | q.nack & ~stopreq
        | ~q.wait_point_sel & q.al & nxt
        | ~q.rsa & q.fe & rx & env.fifo_has_data
        | q.bec & q.bus_fault_flag
        | ~q.dma & ~q.rsa & env.tx_buf_empty
          & (q.dir | ~q.fe)
        | ~q.dma & ~q.wait_point_sel & nxt
          & (env.tx_buf_empty & (m | q.dir)
          | s & rx & ~q.fe & ~q.rsa)
        | ~q.dma & q.fe & s & rx & env.fifo_full
        | q.dma & ~q.rsa & s & env.tx_buf_empty
          & (q.dir | ~q.fe)
        | q.dma & ~q.wait_point_sel & m & nxt & env.tx_bus_idle);

    // Without DMA a write of 1 does not set the flag
    assign set_sw = wr_ctrl & wd[CB_INT] & q.dma;
    assign set_any = set8 | set9 | be_imm | set_sw;
    assign clr = wr_ctrl & (~wd[CB_INT]
        | q.intf & q.act & (~wd[CB_MSS] | wd[CB_SCC]));

    always_comb begin
        n = q;
        // Bit counting on the wire
        if (rs[0] && q.lnk != ST_IDLE && q.cnt < BIT_ACK) begin
            n.cnt = q.cnt + 4'h1;
            if (q.cnt < BIT_DATA) begin
                n.sh = {q.sh[6:0], lv[1]};
            end else begin
                n.nack = lv[1];
            end
        end
        if (at8 && fbq) begin
            n.rsa = rsa8;
            n.dir = q.mrole ? ~q.sh[0] : q.sh[0];
        end
        if (at9) begin
            n.cnt = CNT_RST;
            if (fbq) begin
                n.lnk = ST_NEXT;
            end
        end
        if (env.arb_lost) begin
            n.al = 1'b1;
            n.dir = 1'b0;
        end
        // Conditions on the bus
        if (start) begin
            n.lnk = ST_FIRST;
            n.cnt = CNT_RST;
            n.rsa = 1'b0;
            n.nack = 1'b0;
            n.act = 1'b1;
            n.mrole = q.master_select;
            n.dir = q.master_select;
        end else if (stop) begin
            n.lnk = ST_IDLE;
            n.act = 1'b0;
            n.rsa = 1'b0;
            n.dir = 1'b0;
        end
        if ((start | stop) && mid) begin
            n.bus_fault_flag = 1'b1;
        end
        if (be_imm) begin
            n.lnk = ST_IDLE;
            n.act = 1'b0;
            n.rsa = 1'b0;
            n.dir = 1'b0;
        end
        // Register writes
        if (wr_ctrl) begin
            n.wait_point_sel = wd[CB_WAIT_POINT_SEL];
            n.dma = wd[CB_DMA];
            n.master_select = wd[CB_MSS];
            n.bec = wd[CB_BEC];
            n.allow = wd[CB_ALLOW];
            n.fe = wd[CB_FE];
            n.en = wd[CB_EN];
            if (wd[CB_MSS]) begin
                n.al = 1'b0;
            end
        end
        if (wr_mode) begin
            // Prohibited codes leave the mode untouched
            if (wd[MB_MODE+:3] <= OPM_TWI) begin
                n.mode = wd[MB_MODE+:3];
            end
            n.rx_irq_en = wd[MB_RIE];
            n.tx_irq_en = wd[MB_TIE];
        end
        if (clr) begin
            n.intf = 1'b0;
            n.beri = 1'b0;
            n.bus_fault_flag = 1'b0;
            n.al = 1'b0;
        end
        // A late event still lands after disable, so no gating here
        if (set_any) begin
            n.intf = 1'b1;
            n.beri = be_imm;
        end
        if (!n.en) begin
            n.act = 1'b0;
            n.bus_fault_flag = 1'b0;
            n.rsa = 1'b0;
            n.dir = 1'b0;
            n.al = 1'b0;
            n.lnk = ST_IDLE;
        end
        n.scl_o = 1'b0;
        n.scl_oe_n = ~(n.intf & ~n.beri);
        n.irq.status_irq = n.intf & n.allow
            & ~(n.dma & n.mrole & n.act & (n.lnk == ST_NEXT)
            & env.tx_bus_idle);
        n.irq.rx_irq = n.rx_irq_en & (env.rx_full | env.overrun_flag);
        n.irq.tx_irq = n.tx_irq_en & env.tx_buf_empty;
        // Answer one cycle after setup; zero wait in access
        n.pready = psel & ~penable;
        n.pslverr = psel & ~penable & ~mapped;
        n.prdata = 32'h0;
        if (psel && !penable) begin
            case (ofs)
                ITC_CTRL_OFS: begin
                    n.prdata[CB_INT] = q.intf;
                    n.prdata[CB_WAIT_POINT_SEL] = q.wait_point_sel;
                    n.prdata[CB_DMA] = q.dma;
                    n.prdata[CB_MSS] = q.master_select;
                    n.prdata[CB_SCC] = q.act;
                    n.prdata[CB_BEC] = q.bec;
                    n.prdata[CB_ALLOW] = q.allow;
                    n.prdata[CB_FE] = q.fe;
                    n.prdata[CB_EN] = q.en;
                end
                ITC_MODE_OFS: begin
                    n.prdata[MB_MODE+:3] = q.mode;
                    n.prdata[MB_RIE] = q.rx_irq_en;
                    n.prdata[MB_TIE] = q.tx_irq_en;
                end
                ITC_STAT_OFS: begin
                    n.prdata[SB_ACT] = q.act;
                    n.prdata[SB_FB] = fbq;
                    n.prdata[SB_RSA] = q.rsa;
                    n.prdata[SB_DIR] = q.dir;
                    n.prdata[SB_BER] = q.bus_fault_flag;
                    n.prdata[SB_NACK] = q.nack;
                    n.prdata[SB_AL] = q.al;
                    n.prdata[SB_CNT+:4] = q.cnt;
                end
                default: begin
                    n.prdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.lnk <= ST_IDLE;
            q.mode <= MODE_RST;
            q.scl_oe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign scl_o = q.scl_o;
    assign scl_oe_n = q.scl_oe_n;
    assign irq = q.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ctl_w0;
        wr_ctrl && !pwdata[CB_INT];
    endsequence
    sequence s_ctl_w1_nodma;
        wr_ctrl && pwdata[CB_INT] && !q.dma && !q.intf;
    endsequence

    property p_apb_ready;
        s_setup ##1 (psel && penable) |-> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("no answer in access phase");

    property p_clear;
        s_ctl_w0 ##0 !set_any |=> !q.intf && scl_oe_n;
    endproperty
    a_clear: assert property (p_clear)
        else $error("flag not cleared by writing 0");

    property p_no_set1;
        s_ctl_w1_nodma ##0 !set_any |=> !q.intf;
    endproperty
    a_no_set1: assert property (p_no_set1)
        else $error("write of 1 set flag without DMA");

    property p_hold;
        (q.intf && !q.beri) [*2] |-> !scl_oe_n && !scl_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("clock line not held while flag set");

    property p_rsa8;
        at8 && rsa8 |=> q.intf ##0 q.rsa;
    endproperty
    a_rsa8: assert property (p_rsa8)
        else $error("reserved address did not set flag");

    property p_nack;
        at9 && q.nack && !stopreq |=> q.intf ##1 !scl_oe_n;
    endproperty
    a_nack: assert property (p_nack)
        else $error("NACK did not set flag and hold clock");

    property p_be_imm;
        be_imm |=> q.intf && q.beri && !q.act ##1 scl_oe_n;
    endproperty
    a_be_imm: assert property (p_be_imm)
        else $error("bus error flag wrong");

    property p_mode;
        wr_mode && (pwdata[MB_MODE+:3] > OPM_TWI) |=> $stable(q.mode);
    endproperty
    a_mode: assert property (p_mode)
        else $error("prohibited mode accepted");

    property p_allow;
        !q.allow |-> !irq.status_irq;
    endproperty
    a_allow: assert property (p_allow)
        else $error("status request without enable");

    property p_rxirq;
        irq.rx_irq |-> $past(env.rx_full || env.overrun_flag);
    endproperty
    a_rxirq: assert property (p_rxirq)
        else $error("receive request without cause");
endmodule : itc_ctrl
`default_nettype wire

// file: hdl/itc_pkg.sv
// Shared constants and types of the transfer interrupt controller
package itc_pkg;
    // Register byte offsets
    localparam logic [7:0] ITC_CTRL_OFS = 8'h00;
    localparam logic [7:0] ITC_MODE_OFS = 8'h04;
    localparam logic [7:0] ITC_STAT_OFS = 8'h08;
    // Control register fields
    localparam int CB_INT = 0;
    localparam int CB_WAIT_POINT_SEL = 1;
    localparam int CB_DMA = 2;
    localparam int CB_MSS = 3;
    localparam int CB_SCC = 4;
    localparam int CB_BEC = 5;
    localparam int CB_ALLOW = 6;
    localparam int CB_FE = 7;
    localparam int CB_EN = 8;
    // Mode register fields
    localparam int MB_MODE = 5;
    localparam int MB_RIE = 3;
    localparam int MB_TIE = 2;
    // Status register fields
    localparam int SB_ACT = 0;
    localparam int SB_FB = 1;
    localparam int SB_RSA = 2;
    localparam int SB_DIR = 3;
    localparam int SB_BER = 4;
    localparam int SB_NACK = 5;
    localparam int SB_AL = 6;
    localparam int SB_CNT = 8;
    // Reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [3:0] CNT_RST = 4'h0;
    // Bit positions within a byte on the wire
    localparam logic [3:0] BIT_DATA = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;
    // Reserved address high nibbles
    localparam logic [3:0] RSV_LO = 4'h0;
    localparam logic [3:0] RSV_HI = 4'hf;

    typedef enum logic [2:0] {
        OPM_ASYNC = 3'h0,
        OPM_MULTI = 3'h1,
        OPM_SYNC = 3'h2,
        OPM_LIN = 3'h3,
        OPM_TWI = 3'h4
    } itc_opmode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FIRST = 3'b010,
        ST_NEXT = 3'b100
    } itc_lnk_t;

    // Status from the data path, same clock
    typedef struct packed {
        logic tx_buf_empty;
        logic tx_bus_idle;
        logic rx_full;
        logic overrun_flag;
        logic fifo_has_data;
        logic fifo_full;
        logic arb_lost;
    } itc_env_t;

    typedef struct packed {
        logic status_irq;
        logic rx_irq;
        logic tx_irq;
    } itc_irq_t;
endpackage : itc_pkg

// file: hdl/itc_sync.sv
// Two-stage synchroniser with edge detection per bit
`timescale 1ns/1ps
`default_nettype none
module itc_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous inputs
    input wire logic [W-1:0] din,
    // Synchronised level and edges
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } itc_sy_t;

    itc_sy_t q;
    itc_sy_t n;

    always_comb begin
        n = q;
        n.s1 = din;
        n.s2 = q.s1;
        n.s3 = q.s2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '1;
        end else begin
            q <= n;
        end
    end

    // Edges come from the second and third stage only
    for (genvar i = 0; i < W; i++) begin : g_edge
        assign lvl[i] = q.s2[i];
        assign rise[i] = q.s2[i] & ~q.s3[i];
        assign fall[i] = ~q.s2[i] & q.s3[i];
    end
endmodule : itc_sync
`default_nettype wire

// file: tb/itc_bus_peer.sv
// Far-side bus master model for the two-wire lines
`timescale 1ns/1ps
`default_nettype none
module itc_bus_peer (
    // Wired level of the clock line
    input wire logic scl_ln,
    // Drives, 1 means released to the pull-up
    output logic scl_m,
    output logic sda_m
);
    int stalls = 0;
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // Device may stretch the clock, so wait for the wire itself
    // Changes land on clock edges by non-blocking assignment, so the
    // device's input stage never races the model
    task automatic rel_scl();
        int n;
        n = 0;
        scl_m <= 1'b1;
        while (scl_ln !== 1'b1 && n < 500) begin
            #4;
            n++;
        end
        if (n >= 500) begin
            stalls++;
        end
    endtask : rel_scl
    task automatic start_c();
        sda_m <= 1'b1;
        #40;
        rel_scl();
        #80;
        sda_m <= 1'b0;
        #80;
        scl_m <= 1'b0;
        #40;
    endtask : start_c
    // Clock left low on return, so the device can hold the bus
    task automatic bit_c(input logic b);
        sda_m <= b;
        #40;
        rel_scl();
        #80;
        scl_m <= 1'b0;
        #40;
    endtask : bit_c
    task automatic byte_c(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i]);
        end
    endtask : byte_c
    task automatic stop_c();
        sda_m <= 1'b0;
        #40;
        rel_scl();
        #80;
        sda_m <= 1'b1;
        #40;
    endtask : stop_c
endmodule : itc_bus_peer
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the transfer interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import itc_pkg::*;
    localparam logic [31:0] K_INT = 32'h1 << CB_INT;
    localparam logic [31:0] K_WS = 32'h1 << CB_WAIT_POINT_SEL;
    localparam logic [31:0] K_DMA = 32'h1 << CB_DMA;
    localparam logic [31:0] K_MSS = 32'h1 << CB_MSS;
    localparam logic [31:0] K_SCC = 32'h1 << CB_SCC;
    localparam logic [31:0] K_ALW = 32'h1 << CB_ALLOW;
    localparam logic [31:0] K_FE = 32'h1 << CB_FE;
    localparam logic [31:0] K_EN = 32'h1 << CB_EN;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, scl_o, scl_oe_n;
    logic scl_m, sda_m;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    itc_env_t env;
    itc_irq_t irq;
    wire scl_ln = scl_m & (scl_oe_n | scl_o);
    int num_errors = 0;
    int num_checks = 0;

    always #2 pclk = ~pclk;

    itc_ctrl u_itc_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl_ln), .sda_i(sda_m),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .env(env), .irq(irq)
    );
    itc_bus_peer u_itc_bus_peer (
        .scl_ln(scl_ln), .scl_m(scl_m), .sda_m(sda_m)
    );

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // Request held until the edge that sees pready high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        if (pready !== 1'b1) begin
            num_errors++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r);
    endtask : rd

    task automatic flag(input string nm, input logic exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, ITC_CTRL_OFS, 32'h0, r, e);
        chk(nm, 32'(exp), 32'(r[CB_INT]));
    endtask : flag

    task automatic hold(input string nm, input logic exp);
        repeat (2) @(posedge pclk);
        #1;
        chk(nm, 32'(exp), 32'(scl_oe_n));
    endtask : hold

    task automatic irq_case(input logic rf, input logic ov,
                            input logic te, input logic [2:0] exp);
        @(posedge pclk);
        env.rx_full <= rf;
        env.overrun_flag <= ov;
        env.tx_buf_empty <= te;
        repeat (3) @(posedge pclk);
        #1;
        chk("irq", 32'(exp), 32'(irq));
    endtask : irq_case

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd("ctrl", ITC_CTRL_OFS, 32'h0);
        rd("mode", ITC_MODE_OFS, 32'h0);
        hold("idle release", 1'b1);
        chk("irq reset", 32'h0, 32'(irq));
        chk("scl level", 32'h0, 32'(scl_o));
        apb(1'b0, 8'h0c, 32'h0, r, e);
        chk("unmapped err", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, r);
    endtask : t_reset

    task automatic t_mode();
        wr(ITC_CTRL_OFS, 32'h0);
        for (int m = 0; m < 5; m++) begin
            wr(ITC_MODE_OFS, (32'(m) << MB_MODE) | 32'h13);
            rd("mode code", ITC_MODE_OFS, 32'(m) << MB_MODE);
        end
        wr(ITC_MODE_OFS, 32'ha4);
        rd("bad code", ITC_MODE_OFS, 32'h84);
        wr(ITC_MODE_OFS, 32'h8c);
        rd("enables", ITC_MODE_OFS, 32'h8c);
    endtask : t_mode

    task automatic t_irq();
        irq_case(1'b1, 1'b0, 1'b0, 3'b010);
        irq_case(1'b0, 1'b1, 1'b0, 3'b010);
        irq_case(1'b0, 1'b0, 1'b1, 3'b001);
        irq_case(1'b0, 1'b0, 1'b0, 3'b000);
        wr(ITC_MODE_OFS, 32'h80);
        irq_case(1'b1, 1'b1, 1'b1, 3'b000);
    endtask : t_irq

    task automatic t_rsv();
        wr(ITC_CTRL_OFS, K_EN);
        u_itc_bus_peer.start_c();
        u_itc_bus_peer.byte_c(8'h0e);
        flag("reserved at 8th", 1'b1);
        hold("wait hold", 1'b0);
        chk("masked", 32'h0, 32'(irq.status_irq));
        wr(ITC_CTRL_OFS, K_EN);
        flag("write 0 clears", 1'b0);
        hold("release", 1'b1);
        u_itc_bus_peer.bit_c(1'b0);
        u_itc_bus_peer.stop_c();
    endtask : t_rsv

    task automatic t_rx9();
        wr(ITC_CTRL_OFS, K_EN | K_ALW);
        u_itc_bus_peer.start_c();
        u_itc_bus_peer.byte_c(8'ha4);
        flag("none at 8th", 1'b0);
        u_itc_bus_peer.bit_c(1'b0);
        flag("rx at 9th", 1'b1);
        hold("wait hold", 1'b0);
        chk("status_irq", 32'h1, 32'(irq.status_irq));
        wr(ITC_CTRL_OFS, K_EN | K_ALW | K_WS | K_INT);
        flag("master off clears", 1'b0);
        u_itc_bus_peer.byte_c(8'h5a);
        flag("wait_point_sel 1 at 8th", 1'b1);
        wr(ITC_CTRL_OFS, K_EN | K_WS | K_MSS | K_SCC | K_INT);
        flag("restart clears", 1'b0);
        @(posedge pclk);
        env.tx_buf_empty <= 1'b0;
        wr(ITC_CTRL_OFS, K_EN | K_WS);
        u_itc_bus_peer.bit_c(1'b1);
        flag("nack at 9th", 1'b1);
        wr(ITC_CTRL_OFS, K_EN);
        u_itc_bus_peer.stop_c();
    endtask : t_rx9

    task automatic t_dma();
        wr(ITC_CTRL_OFS, K_EN | K_INT);
        flag("set ignored", 1'b0);
        wr(ITC_CTRL_OFS, K_EN | K_DMA);
        wr(ITC_CTRL_OFS, K_EN | K_DMA | K_INT);
        flag("set with dma", 1'b1);
        hold("dma hold", 1'b0);
        wr(ITC_CTRL_OFS, K_EN | K_DMA);
        flag("dma clear", 1'b0);
        wr(ITC_CTRL_OFS, K_EN | K_DMA | K_INT);
        flag("set again", 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        flag("reset clears", 1'b0);
        hold("reset release", 1'b1);
    endtask : t_dma

    task automatic t_berr();
        wr(ITC_CTRL_OFS, K_EN | K_ALW);
        u_itc_bus_peer.start_c();
        u_itc_bus_peer.bit_c(1'b1);
        u_itc_bus_peer.bit_c(1'b0);
        u_itc_bus_peer.bit_c(1'b1);
        u_itc_bus_peer.start_c();
        flag("bus error", 1'b1);
        hold("no hold on error", 1'b1);
        wr(ITC_CTRL_OFS, K_EN);
        u_itc_bus_peer.stop_c();
    endtask : t_berr

    // FIFO receive as slave, then as master with a lost arbitration
    task automatic t_fifo();
        wr(ITC_CTRL_OFS, K_EN | K_FE);
        u_itc_bus_peer.start_c();
        u_itc_bus_peer.byte_c(8'ha4);
        u_itc_bus_peer.bit_c(1'b0);
        flag("fifo empty", 1'b0);
        env.fifo_full <= 1'b1;
        u_itc_bus_peer.byte_c(8'h11);
        u_itc_bus_peer.bit_c(1'b0);
        flag("slave fifo full", 1'b1);
        env.fifo_full <= 1'b0;
        env.fifo_has_data <= 1'b1;
        wr(ITC_CTRL_OFS, K_EN | K_FE);
        u_itc_bus_peer.byte_c(8'h22);
        u_itc_bus_peer.bit_c(1'b0);
        flag("fifo data", 1'b1);
        env.fifo_has_data <= 1'b0;
        env.fifo_full <= 1'b1;
        wr(ITC_CTRL_OFS, K_EN | K_FE | K_MSS);
        u_itc_bus_peer.stop_c();
        u_itc_bus_peer.start_c();
        u_itc_bus_peer.byte_c(8'ha5);
        u_itc_bus_peer.bit_c(1'b0);
        flag("master fifo full", 1'b0);
        env.arb_lost <= 1'b1;
        @(posedge pclk);
        env.arb_lost <= 1'b0;
        u_itc_bus_peer.byte_c(8'h33);
        flag("lost not at 8th", 1'b0);
        u_itc_bus_peer.bit_c(1'b0);
        flag("lost at 9th", 1'b1);
        env.fifo_full <= 1'b0;
        wr(ITC_CTRL_OFS, K_EN | K_FE | K_MSS);
        u_itc_bus_peer.stop_c();
    endtask : t_fifo

    // DMA master with the transmit bus idle over the first byte and the eight data bits of the second
    task automatic t_idle();
        wr(ITC_CTRL_OFS, K_EN | K_ALW | K_DMA | K_WS | K_MSS);
        env.tx_bus_idle <= 1'b1;
        u_itc_bus_peer.start_c();
        u_itc_bus_peer.byte_c(8'ha4);
        u_itc_bus_peer.bit_c(1'b0);
        flag("idle in byte one", 1'b0);
        u_itc_bus_peer.byte_c(8'h44);
        flag("idle at 8th", 1'b1);
        chk("idle status_irq", 32'h0, 32'(irq.status_irq));
        env.tx_bus_idle <= 1'b0;
        wr(ITC_CTRL_OFS, K_EN | K_ALW | K_DMA | K_WS | K_MSS);
        u_itc_bus_peer.bit_c(1'b0);
        u_itc_bus_peer.stop_c();
    endtask : t_idle

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        env = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mode();
        t_irq();
        t_rsv();
        t_rx9();
        t_dma();
        t_berr();
        t_fifo();
        t_idle();
        chk("clock stalls", 32'h0, 32'(u_itc_bus_peer.stalls));
        end_sim();
    end

    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
